// ### verilog/gpi_preset_alarm_port.sv
// Notes on behaviour
// - Input pulses under 40 ms are dropped and pulses over 60 ms are always seen.
// - An open input reads as inactive high.
// - In preset mode dual, second, third levels HHL..LLL select presets 1..7.
// - With the dual input on another function only presets 1 to 3 exist.
// - Inputs are active low and a recall fires on a high to low transition only.
// - The dual input does exactly one of preset, time reset, reacquire, jam, none.
// - Three active low alarm outputs idle high and each enabled output goes low on an enabled error.
// - Hardware, supply, lock and timing sources each have their own enable.
// - Near loss of lock is raised within about 2e-6 of either tuning end.
// - With blanking chosen, the second reference output is off while unlocked.
// - A delayed error alarms only if it lasts until the countdown ends.
`timescale 1ns/100ps
`default_nettype none

module gpi_preset_alarm_port #(
  parameter int unsigned FILTER_CYC = gpi_pkg::FILTER_CYC,
  parameter int unsigned MS_CYC     = gpi_pkg::MS_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [2:0]  gpi_in_n,
  input  wire logic [2:0]  dual_func,
  input  wire logic        hw_fault,
  input  wire logic        ps_fault,
  input  wire logic        lock_lost,
  input  wire logic        lock_warn,
  input  wire logic        timing_err,
  input  wire logic [31:0] tune_val,
  input  wire logic [31:0] tune_lo,
  input  wire logic [31:0] tune_hi,
  input  wire logic [3:0]  alarm_src_en,
  input  wire logic [2:0]  alarm_out_en,
  input  wire logic [15:0] src_delay_ms,
  input  wire logic        ref2_blank_en,
  output logic             recall_r,
  output logic [2:0]       preset_r,
  output logic             time_reset_r,
  output logic             pos_reacq_r,
  output logic             jam_sync_r,
  output logic             near_lock_r,
  output logic [2:0]       alarm_n_r,
  output logic             ref2_on_r
);

  // ----------------------------------------------------------------
  // Synchronise and qualify inputs
  // ----------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] filt_r;
  logic [2:0] filt_nxt;
  logic [2:0] fall;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= {3{gpi_pkg::PIN_IDLE}};
      sync2_r <= {3{gpi_pkg::PIN_IDLE}};
    end else begin
      sync1_r <= gpi_in_n;
      sync2_r <= sync1_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < gpi_pkg::IN_NUM; gi++) begin : g_filt
      logic [gpi_pkg::FILTER_CNT_W-1:0] cnt_r;
      logic [gpi_pkg::FILTER_CNT_W-1:0] cnt_nxt;
      always_comb begin
        cnt_nxt       = '0;
        filt_nxt[gi]  = filt_r[gi];
        if (sync2_r[gi] != filt_r[gi]) begin
          if (cnt_r == gpi_pkg::FILTER_CNT_W'(FILTER_CYC - 1)) begin
            filt_nxt[gi] = sync2_r[gi];
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          cnt_r      <= '0;
          filt_r[gi] <= gpi_pkg::PIN_IDLE;
        end else begin
          cnt_r      <= cnt_nxt;
          filt_r[gi] <= filt_nxt[gi];
        end
      end
      assign fall[gi] = filt_r[gi] & ~filt_nxt[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Preset decode and dual purpose actions
  // ----------------------------------------------------------------
  logic       preset_mode;
  logic [2:0] code;
  logic       recall_nxt;
  logic [2:0] preset_nxt;
  logic       time_reset_nxt;
  logic       pos_reacq_nxt;
  logic       jam_sync_nxt;
  logic       dual_fall;

  always_comb begin
    preset_mode    = (dual_func == gpi_pkg::FUNC_PRESET);
    dual_fall      = fall[gpi_pkg::IN_DUAL];
    code           = {preset_mode & ~filt_nxt[gpi_pkg::IN_DUAL],
                      ~filt_nxt[gpi_pkg::IN_SECOND],
                      ~filt_nxt[gpi_pkg::IN_THIRD]};
    recall_nxt     = 1'b0;
    preset_nxt     = preset_r;
    time_reset_nxt = 1'b0;
    pos_reacq_nxt  = 1'b0;
    jam_sync_nxt   = 1'b0;
    if ((fall[gpi_pkg::IN_SECOND] | fall[gpi_pkg::IN_THIRD] |
         (dual_fall & preset_mode)) && code != 3'h0) begin
      recall_nxt = 1'b1;
      preset_nxt = code;
    end
    if (dual_fall) begin
      case (dual_func)
        gpi_pkg::FUNC_TIME_RESET: time_reset_nxt = 1'b1;
        gpi_pkg::FUNC_POS_REACQ:  pos_reacq_nxt  = 1'b1;
        gpi_pkg::FUNC_JAM_SYNC:   jam_sync_nxt   = 1'b1;
        default:                  ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      recall_r     <= 1'b0;
      preset_r     <= 3'h0;
      time_reset_r <= 1'b0;
      pos_reacq_r  <= 1'b0;
      jam_sync_r   <= 1'b0;
    end else begin
      recall_r     <= recall_nxt;
      preset_r     <= preset_nxt;
      time_reset_r <= time_reset_nxt;
      pos_reacq_r  <= pos_reacq_nxt;
      jam_sync_r   <= jam_sync_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Near loss of lock and millisecond tick
  // ----------------------------------------------------------------
  logic                         near_nxt;
  logic [gpi_pkg::MS_CNT_W-1:0] ms_cnt_r;
  logic [gpi_pkg::MS_CNT_W-1:0] ms_cnt_nxt;
  logic                         ms_tick;

  always_comb begin
    near_nxt = (tune_val <= tune_lo + gpi_pkg::NEAR_LOCK_MARGIN) ||
               (tune_val + gpi_pkg::NEAR_LOCK_MARGIN >= tune_hi);
    ms_tick    = (ms_cnt_r == gpi_pkg::MS_CNT_W'(MS_CYC - 1));
    ms_cnt_nxt = ms_tick ? '0 : ms_cnt_r + 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      near_lock_r <= 1'b0;
      ms_cnt_r    <= '0;
    end else begin
      near_lock_r <= near_nxt;
      ms_cnt_r    <= ms_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Source persistence
  // ----------------------------------------------------------------
  logic [3:0] src_raw;
  logic [3:0] src_qual;

  assign src_raw = {timing_err, lock_lost | lock_warn | near_lock_r,
                    ps_fault, hw_fault};

  generate
    for (gi = 0; gi < gpi_pkg::SRC_NUM; gi++) begin : g_delay
      logic [gpi_pkg::DELAY_W-1:0] dly_r;
      logic [gpi_pkg::DELAY_W-1:0] dly_nxt;
      always_comb begin
        dly_nxt = '0;
        if (src_raw[gi] && dly_r < src_delay_ms) begin
          dly_nxt = ms_tick ? dly_r + 1'b1 : dly_r;
        end else if (src_raw[gi]) begin
          dly_nxt = dly_r;
        end
      end
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          dly_r <= '0;
        end else begin
          dly_r <= dly_nxt;
        end
      end
      assign src_qual[gi] = src_raw[gi] && (dly_r >= src_delay_ms);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Alarm outputs and reference blanking
  // ----------------------------------------------------------------
  logic [2:0] alarm_n_nxt;
  logic       ref2_on_nxt;
  logic       any_alarm;

  always_comb begin
    any_alarm   = |(src_qual & alarm_src_en);
    alarm_n_nxt = ~(alarm_out_en & {3{any_alarm}});
    ref2_on_nxt = ~(ref2_blank_en & lock_lost);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_n_r <= 3'h7;
      ref2_on_r <= 1'b1;
    end else begin
      alarm_n_r <= alarm_n_nxt;
      ref2_on_r <= ref2_on_nxt;
    end
  end

endmodule

`default_nettype wire

// ### verilog/gpi_pkg.sv
`default_nettype none
package gpi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned FILTER_MS     = 50;
  localparam int unsigned FILTER_CYC    = (CLK_HZ / 1000) * FILTER_MS;
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  localparam int unsigned FILTER_CNT_W  = 22;
  localparam int unsigned MS_CNT_W      = 16;
  localparam int unsigned DELAY_W       = 16;

  // ----------------------------------------------------------------
  // Tuning margin, units of 1e-9 fractional frequency
  // ----------------------------------------------------------------
  localparam logic [31:0] NEAR_LOCK_MARGIN = 32'h0000_07d0;

  // ----------------------------------------------------------------
  // Pins, sources, outputs
  // ----------------------------------------------------------------
  localparam int unsigned IN_NUM     = 3;
  localparam int unsigned IN_THIRD   = 0;
  localparam int unsigned IN_SECOND  = 1;
  localparam int unsigned IN_DUAL    = 2;
  localparam int unsigned SRC_NUM    = 4;
  localparam int unsigned SRC_HW     = 0;
  localparam int unsigned SRC_PS     = 1;
  localparam int unsigned SRC_LOCK   = 2;
  localparam int unsigned SRC_TIMING = 3;
  localparam int unsigned ALARM_NUM  = 3;
  localparam logic        PIN_IDLE   = 1'b1;

  // ----------------------------------------------------------------
  // Function of the dual purpose input
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FUNC_PRESET     = 3'h0,
    FUNC_TIME_RESET = 3'h1,
    FUNC_POS_REACQ  = 3'h2,
    FUNC_JAM_SYNC   = 3'h3,
    FUNC_NONE       = 3'h4
  } dual_func_t;

endpackage
`default_nettype wire

// ### tb/contact_bank.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Contact closures on the rear pins
// ----------------------------------------
module contact_bank (
  input  wire logic [2:0] close_req,
  output wire logic [2:0] pin_n
);
  // Open contacts float to the pull-up level
  assign pin_n = ~close_req;
endmodule
`default_nettype wire

// ### tb/port_alarm_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module port_alarm_chk (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [2:0]  gpi_in_n,
  input wire logic [2:0]  dual_func,
  input wire logic        hw_fault,
  input wire logic        lock_lost,
  input wire logic [31:0] tune_val,
  input wire logic [31:0] tune_lo,
  input wire logic [31:0] tune_hi,
  input wire logic [3:0]  alarm_src_en,
  input wire logic [2:0]  alarm_out_en,
  input wire logic [15:0] src_delay_ms,
  input wire logic        ref2_blank_en,
  input wire logic        recall_r,
  input wire logic [2:0]  preset_r,
  input wire logic        near_lock_r,
  input wire logic [2:0]  alarm_n_r,
  input wire logic        ref2_on_r
);
  logic near_now;
  logic blank_now;
  assign near_now = (tune_val <= tune_lo + gpi_pkg::NEAR_LOCK_MARGIN) ||
                    (tune_val + gpi_pkg::NEAR_LOCK_MARGIN >= tune_hi);
  assign blank_now = ref2_blank_en & lock_lost;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  recall_pulse_a: assert property (recall_r |=> !recall_r)
    else $error("recall wider than one cycle");
  quiet_pins_a: assert property (
    (gpi_in_n == 3'h7) [*8] |=> !recall_r) else $error("recall on idle");
  preset_range_a: assert property (recall_r |-> preset_r != 3'h0)
    else $error("preset zero");
  short_range_a: assert property (
    recall_r && dual_func != 3'h0 |-> preset_r <= 3'h3)
    else $error("preset above three");
  hw_alarm_a: assert property (
    hw_fault && alarm_src_en[0] && src_delay_ms == 16'h0
    |=> (alarm_n_r & $past(alarm_out_en)) == 3'h0)
    else $error("alarm missing");
  src_off_a: assert property (
    (alarm_src_en == 4'h0) [*2] |=> alarm_n_r == 3'h7)
    else $error("alarm while disabled");
  near_track_a: assert property (near_lock_r == $past(near_now))
    else $error("near lock wrong");
  ref2_track_a: assert property (ref2_on_r != $past(blank_now))
    else $error("ref2 state wrong");
endmodule
bind gpi_preset_alarm_port port_alarm_chk i_port_alarm_chk (
  .mclk, .rst_b, .gpi_in_n, .dual_func, .hw_fault, .lock_lost, .tune_val,
  .tune_lo, .tune_hi, .alarm_src_en, .alarm_out_en, .src_delay_ms,
  .ref2_blank_en, .recall_r, .preset_r, .near_lock_r, .alarm_n_r, .ref2_on_r
);
`default_nettype wire

// ### tb/gpi_preset_alarm_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Testbench
// ----------------------------------------
module gpi_preset_alarm_port_tb_top;
  localparam int FILT = 8;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [2:0]  close_req = 3'h0;
  logic [2:0]  pins_n;
  logic [2:0]  dual_func = 3'h0;
  logic        hw_fault = 1'b0;
  logic        ps_fault = 1'b0;
  logic        lock_warn = 1'b0;
  logic        lock_lost = 1'b0;
  logic        timing_err = 1'b0;
  logic [31:0] tune_val = 32'h0000_c350;
  logic [3:0]  src_en = 4'h0;
  logic [2:0]  out_en = 3'h0;
  logic [15:0] dly = 16'h0;
  logic        blank_en = 1'b0;
  logic        recall_r, time_reset_r, pos_reacq_r, jam_sync_r;
  logic        near_lock_r, ref2_on_r;
  logic [2:0]  preset_r, alarm_n_r;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #10 mclk = ~mclk;
  contact_bank i_contact_bank (.close_req(close_req), .pin_n(pins_n));
  gpi_preset_alarm_port #(.FILTER_CYC(FILT), .MS_CYC(4))
    i_gpi_preset_alarm_port (
    .mclk, .rst_b, .gpi_in_n(pins_n), .dual_func, .hw_fault,
    .ps_fault, .lock_lost, .lock_warn, .timing_err, .tune_val,
    .tune_lo(32'h0), .tune_hi(32'h0001_86a0), .alarm_src_en(src_en),
    .alarm_out_en(out_en), .src_delay_ms(dly), .ref2_blank_en(blank_en),
    .recall_r, .preset_r, .time_reset_r, .pos_reacq_r, .jam_sync_r,
    .near_lock_r, .alarm_n_r, .ref2_on_r);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic watch(int n, logic [2:0] e);
    logic [2:0] acc;
    acc = 3'h7;
    repeat (n) begin
      tick(1);
      acc &= alarm_n_r;
    end
    chk("alarm_seen", e, acc);
  endtask
  task automatic press(logic [2:0] m, logic [2:0] f, int hold,
                       logic [3:0] ev, logic [2:0] ep);
    logic [3:0] seen;
    int         nrec;
    int         lat;
    seen = 4'h0;
    nrec = 0;
    lat = 0;
    @(posedge mclk);
    dual_func <= f;
    close_req <= m;
    for (int i = 1; i < hold + 24; i++) begin
      @(posedge mclk);
      if (i == hold) close_req <= 3'h0;
      #1;
      seen |= {jam_sync_r, pos_reacq_r, time_reset_r, recall_r};
      if (recall_r === 1'b1) begin
        nrec++;
        lat = i;
      end
    end
    chk("events", ev, seen);
    chk("recalls", ev[0], nrec);
    chk("preset", ep, preset_r);
    if (ev[0]) chk("latency", FILT + 2, lat);
  endtask
  task automatic t_src_mask;
    @(posedge mclk);
    out_en <= 3'h5;
    hw_fault <= 1'b1;
    ps_fault <= 1'b1;
    lock_warn <= 1'b1;
    tick(3);
    chk("alarm_none", 3'h7, alarm_n_r);
    @(posedge mclk);
    hw_fault <= 1'b0;
    lock_warn <= 1'b0;
    src_en <= 4'h2;
    tick(2);
    chk("alarm_ps", 3'h2, alarm_n_r);
    @(posedge mclk);
    ps_fault <= 1'b0;
    lock_warn <= 1'b1;
    src_en <= 4'h4;
    tick(2);
    chk("alarm_warn", 3'h2, alarm_n_r);
    @(posedge mclk);
    lock_warn <= 1'b0;
    tick(2);
    chk("alarm_clear", 3'h7, alarm_n_r);
  endtask
  task automatic t_alarm;
    @(posedge mclk);
    src_en <= 4'h1;
    out_en <= 3'h5;
    hw_fault <= 1'b1;
    tick(2);
    chk("alarm_hw", 3'h2, alarm_n_r);
    @(posedge mclk);
    src_en <= 4'he;
    tick(2);
    chk("alarm_mask", 3'h7, alarm_n_r);
    @(posedge mclk);
    hw_fault <= 1'b0;
    src_en <= 4'h8;
    dly <= 16'h2;
    timing_err <= 1'b1;
    tick(1);
    @(posedge mclk);
    timing_err <= 1'b0;
    watch(14, 3'h7);
    @(posedge mclk);
    timing_err <= 1'b1;
    watch(4, 3'h7);
    watch(12, 3'h2);
    @(posedge mclk);
    timing_err <= 1'b0;
    dly <= 16'h0;
    src_en <= 4'h4;
    lock_lost <= 1'b1;
    blank_en <= 1'b1;
    tick(2);
    chk("ref2_off", 1'b0, ref2_on_r);
    chk("alarm_lock", 3'h2, alarm_n_r);
    @(posedge mclk);
    lock_lost <= 1'b0;
    tune_val <= 32'h0000_03e8;
    tick(3);
    chk("ref2_on", 1'b1, ref2_on_r);
    chk("near", 1'b1, near_lock_r);
    chk("alarm_near", 3'h2, alarm_n_r);
    @(posedge mclk);
    tune_val <= 32'h0000_c350;
    tick(3);
    chk("near_off", 1'b0, near_lock_r);
    chk("alarm_off", 3'h7, alarm_n_r);
    @(posedge mclk);
    tune_val <= 32'h0001_82b8;
    tick(2);
    chk("near_hi", 1'b1, near_lock_r);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    tick(1);
    chk("alarm_rst", 3'h7, alarm_n_r);
    for (int c = 1; c < 8; c++) begin
      press(c[2:0], 3'h0, 24, 4'h1, c[2:0]);
    end
    press(3'h7, 3'h3, 24, 4'h9, 3'h3);
    press(3'h4, 3'h1, 24, 4'h2, 3'h3);
    press(3'h4, 3'h2, 24, 4'h4, 3'h3);
    press(3'h4, 3'h4, 24, 4'h0, 3'h3);
    press(3'h2, 3'h0, 5, 4'h0, 3'h3);
    press(3'h2, 3'h0, 8, 4'h1, 3'h2);
    t_src_mask;
    t_alarm;
    end_sim;
  end
endmodule
`default_nettype wire
